// >>> sspf_device_end.sv
// Sensor end: parses host packets, frames responses and the sentence
//
// Design decisions made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module sspf_device_end (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          sys_rst,
	// Link
	sspf_link_if.device        link,
	// Received packets
	output logic               wr_en,
	output logic [7:0]         wr_addr,
	output logic [31:0]        wr_data,
	output logic               wr_hidden,
	output logic               rd_req,
	output logic [7:0]         rd_addr,
	output logic [4:0]         rd_count,
	output logic               rd_hidden,
	output logic               pkt_dropped,
	// Binary responses
	input  wire logic          tx_req,
	input  wire logic [7:0]    tx_pt,
	input  wire logic [7:0]    tx_addr,
	input  wire logic [31:0]   tx_word,
	output logic [3:0]         tx_word_idx,
	output logic               tx_busy,
	// Quaternion sentence
	input  wire logic          quat_mode,
	input  wire logic          q_req,
	input  wire logic [51:0]   q_time_bcd,
	input  wire logic [127:0]  q_elem_bcd,
	input  wire logic [3:0]    q_elem_neg
);
	// ----------------------------------------------------------------
	// Receive parser
	// ----------------------------------------------------------------
	sspf_pkg::sspf_rx_t rx_st_r;
	logic [7:0]  pt_r;
	logic [7:0]  adr_r;
	logic [7:0]  ck_hi_r;
	logic [15:0] rsum_r;
	logic [5:0]  cnt_r;
	logic [31:0] mem [16];
	logic        take;
	logic [7:0]  b;
	logic [6:0]  rlen;

	assign link.h2d_ready = (rx_st_r != sspf_pkg::RX_OUT);
	assign take = link.h2d_valid && link.h2d_ready;
	assign b = link.h2d_data;
	assign rlen = sspf_pkg::data_len(pt_r);

	always_ff @(posedge clk) begin
		if (take && rx_st_r == sspf_pkg::RX_DAT)
			mem[cnt_r[5:2]] <= {mem[cnt_r[5:2]][23:0], b};
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_st_r <= sspf_pkg::RX_S;
			pt_r <= sspf_pkg::BYTE_RST;
			adr_r <= sspf_pkg::BYTE_RST;
			ck_hi_r <= sspf_pkg::BYTE_RST;
			rsum_r <= sspf_pkg::SUM_RST;
			cnt_r <= 6'h00;
			wr_en <= 1'b0;
			wr_addr <= sspf_pkg::BYTE_RST;
			wr_data <= 32'h0000_0000;
			wr_hidden <= 1'b0;
			rd_req <= 1'b0;
			rd_addr <= sspf_pkg::BYTE_RST;
			rd_count <= 5'h00;
			rd_hidden <= 1'b0;
			pkt_dropped <= 1'b0;
		end else begin
			wr_en <= 1'b0;
			rd_req <= 1'b0;
			pkt_dropped <= 1'b0;
			unique case (rx_st_r)
				sspf_pkg::RX_S: if (take && b == sspf_pkg::SYNC_S) begin
					rx_st_r <= sspf_pkg::RX_N;
					rsum_r <= {8'h00, sspf_pkg::SYNC_S};
				end
				sspf_pkg::RX_N: if (take) begin
					rsum_r <= 16'(rsum_r + {8'h00, b});
					if (b == sspf_pkg::SYNC_N)
						rx_st_r <= sspf_pkg::RX_P;
					else if (b == sspf_pkg::SYNC_S)
						rsum_r <= {8'h00, sspf_pkg::SYNC_S};
					else
						rx_st_r <= sspf_pkg::RX_S;
				end
				sspf_pkg::RX_P: if (take) begin
					rsum_r <= 16'(rsum_r + {8'h00, b});
					if (b == sspf_pkg::SYNC_P)
						rx_st_r <= sspf_pkg::RX_PT;
					else if (b == sspf_pkg::SYNC_S) begin
						rx_st_r <= sspf_pkg::RX_N;
						rsum_r <= {8'h00, sspf_pkg::SYNC_S};
					end else
						rx_st_r <= sspf_pkg::RX_S;
				end
				sspf_pkg::RX_PT: if (take) begin
					pt_r <= b;
					cnt_r <= 6'h00;
					rsum_r <= 16'(rsum_r + {8'h00, b});
					rx_st_r <= sspf_pkg::RX_ADR;
				end
				sspf_pkg::RX_ADR: if (take) begin
					adr_r <= b;
					rsum_r <= 16'(rsum_r + {8'h00, b});
					rx_st_r <= (rlen == 7'h00) ? sspf_pkg::RX_CK1
						: sspf_pkg::RX_DAT;
				end
				sspf_pkg::RX_DAT: if (take) begin
					rsum_r <= 16'(rsum_r + {8'h00, b});
					cnt_r <= 6'(cnt_r + 6'h01);
					if ({1'b0, cnt_r} == 7'(rlen - 7'h01))
						rx_st_r <= sspf_pkg::RX_CK1;
				end
				sspf_pkg::RX_CK1: if (take) begin
					ck_hi_r <= b;
					rx_st_r <= sspf_pkg::RX_CK0;
				end
				sspf_pkg::RX_CK0: if (take) begin
					cnt_r <= 6'h00;
					if ({ck_hi_r, b} == rsum_r && sspf_pkg::pt_ok(pt_r))
						rx_st_r <= sspf_pkg::RX_OUT;
					else begin
						pkt_dropped <= 1'b1;
						rx_st_r <= sspf_pkg::RX_S;
					end
				end
				sspf_pkg::RX_OUT: begin
					if (pt_r[sspf_pkg::PT_DATA] &&
							cnt_r != {1'b0, sspf_pkg::reg_count(pt_r)}) begin
						wr_en <= 1'b1;
						wr_addr <= 8'(adr_r + {2'b00, cnt_r});
						wr_data <= mem[cnt_r[3:0]];
						wr_hidden <= pt_r[sspf_pkg::PT_HIDDEN];
						cnt_r <= 6'(cnt_r + 6'h01);
					end else begin
						if (!pt_r[sspf_pkg::PT_DATA]) begin
							rd_req <= 1'b1;
							rd_addr <= adr_r;
							rd_count <= sspf_pkg::reg_count(pt_r);
							rd_hidden <= pt_r[sspf_pkg::PT_HIDDEN];
						end
						rx_st_r <= sspf_pkg::RX_S;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Transmit: binary response or quaternion sentence
	// ----------------------------------------------------------------
	sspf_pkg::sspf_tx_t tx_st_r;
	logic [6:0]   step_r;
	logic [7:0]   tpt_r;
	logic [7:0]   tadr_r;
	logic [15:0]  tsum_r;
	logic         tval_r;
	logic [7:0]   tdat_r;
	logic [51:0]  time_r;
	logic [127:0] elem_r;
	logic [3:0]   neg_r;
	logic [2:0]   af_r;
	logic [3:0]   di_r;
	logic         lead_r;
	logic [7:0]   x_r;
	logic         slot;
	logic [6:0]   tlen;
	logic [6:0]   k;
	logic [7:0]   bin_byte;
	logic [51:0]  fdig;
	logic [3:0]   last_int;
	logic [3:0]   dig;
	logic [1:0]   ei;
	logic [7:0]   ac;
	logic         aemit;
	logic         axor;

	assign link.d2h_valid = tval_r;
	assign link.d2h_data = tdat_r;
	assign slot = !tval_r || link.d2h_ready;
	assign tlen = sspf_pkg::data_len(tpt_r);
	assign k = 7'(step_r - sspf_pkg::STEP_DATA);
	assign tx_word_idx = k[5:2];
	assign tx_busy = (tx_st_r != sspf_pkg::TX_IDLE);
	assign ei = 2'(af_r - 3'h1);
	assign last_int = (af_r == 3'h0) ? sspf_pkg::TIME_LAST_INT
		: sspf_pkg::QUAT_LAST_INT;
	assign fdig = (af_r == 3'h0) ? time_r
		: {20'h0_0000, elem_r[{ei, 5'h00} +: 32]};
	assign dig = fdig[{4'(sspf_pkg::LAST_DIGIT - di_r), 2'b00} +: 4];

	always_comb begin
		if (step_r == 7'h00)
			bin_byte = sspf_pkg::SYNC_S;
		else if (step_r == 7'h01)
			bin_byte = sspf_pkg::SYNC_N;
		else if (step_r == 7'h02)
			bin_byte = sspf_pkg::SYNC_P;
		else if (step_r == 7'h03)
			bin_byte = tpt_r;
		else if (step_r == 7'h04)
			bin_byte = tadr_r;
		else if (k < tlen)
			bin_byte = tx_word[{~k[1:0], 3'b000} +: 8];
		else if (k == tlen)
			bin_byte = tsum_r[15:8];
		else
			bin_byte = tsum_r[7:0];
	end

	always_comb begin
		ac = sspf_pkg::ASC_COMMA;
		aemit = 1'b1;
		axor = 1'b1;
		unique case (tx_st_r)
			sspf_pkg::TX_HDR: begin
				ac = sspf_pkg::hdr_char(af_r == 3'h0 ? di_r[2:0] : 3'h0);
				axor = (di_r != 4'h0);
			end
			sspf_pkg::TX_SIGN: begin
				ac = sspf_pkg::ASC_MINUS;
				aemit = (af_r != 3'h0) && neg_r[ei];
			end
			sspf_pkg::TX_DIG: begin
				ac = sspf_pkg::ASC_ZERO | {4'h0, dig};
				aemit = !(dig == 4'h0 && !lead_r && di_r < last_int);
			end
			sspf_pkg::TX_DOT: ac = sspf_pkg::ASC_DOT;
			sspf_pkg::TX_STAR: begin
				ac = sspf_pkg::ASC_STAR;
				axor = 1'b0;
			end
			sspf_pkg::TX_HX1: begin
				ac = sspf_pkg::hex_char(x_r[7:4]);
				axor = 1'b0;
			end
			sspf_pkg::TX_HX0: begin
				ac = sspf_pkg::hex_char(x_r[3:0]);
				axor = 1'b0;
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_st_r <= sspf_pkg::TX_IDLE;
			step_r <= 7'h00;
			tpt_r <= sspf_pkg::BYTE_RST;
			tadr_r <= sspf_pkg::BYTE_RST;
			tsum_r <= sspf_pkg::SUM_RST;
			tval_r <= 1'b0;
			tdat_r <= sspf_pkg::BYTE_RST;
			time_r <= 52'h0;
			elem_r <= 128'h0;
			neg_r <= 4'h0;
			af_r <= 3'h0;
			di_r <= 4'h0;
			lead_r <= 1'b0;
			x_r <= sspf_pkg::BYTE_RST;
		end else begin
			if (slot)
				tval_r <= 1'b0;
			if (tx_st_r == sspf_pkg::TX_IDLE) begin
				step_r <= 7'h00;
				tsum_r <= sspf_pkg::SUM_RST;
				af_r <= 3'h0;
				di_r <= 4'h0;
				x_r <= sspf_pkg::BYTE_RST;
				if (tx_req) begin
					tx_st_r <= sspf_pkg::TX_BIN;
					tpt_r <= tx_pt;
					tadr_r <= tx_addr;
				end else if (q_req && quat_mode) begin
					tx_st_r <= sspf_pkg::TX_HDR;
					time_r <= q_time_bcd;
					elem_r <= q_elem_bcd;
					neg_r <= q_elem_neg;
				end
			end else if (slot && tx_st_r == sspf_pkg::TX_BIN) begin
				tval_r <= 1'b1;
				tdat_r <= bin_byte;
				step_r <= 7'(step_r + 7'h01);
				if (k < tlen || step_r < sspf_pkg::STEP_DATA)
					tsum_r <= 16'(tsum_r + {8'h00, bin_byte});
				if (k == 7'(tlen + 7'h01))
					tx_st_r <= sspf_pkg::TX_IDLE;
			end else if (slot) begin
				tval_r <= aemit;
				tdat_r <= ac;
				if (aemit && axor)
					x_r <= x_r ^ ac;
				unique case (tx_st_r)
					sspf_pkg::TX_HDR: begin
						di_r <= 4'(di_r + 4'h1);
						if (di_r[2:0] == sspf_pkg::HDR_LAST)
							tx_st_r <= sspf_pkg::TX_COMMA;
					end
					sspf_pkg::TX_COMMA: tx_st_r <= (af_r == sspf_pkg::FIELDS)
						? sspf_pkg::TX_STAR : sspf_pkg::TX_SIGN;
					sspf_pkg::TX_SIGN: begin
						di_r <= 4'h0;
						lead_r <= 1'b0;
						tx_st_r <= sspf_pkg::TX_DIG;
					end
					sspf_pkg::TX_DIG: begin
						lead_r <= lead_r || aemit;
						if (di_r == sspf_pkg::LAST_DIGIT) begin
							af_r <= 3'(af_r + 3'h1);
							tx_st_r <= sspf_pkg::TX_COMMA;
						end else if (di_r == last_int)
							tx_st_r <= sspf_pkg::TX_DOT;
						else
							di_r <= 4'(di_r + 4'h1);
					end
					sspf_pkg::TX_DOT: begin
						di_r <= 4'(di_r + 4'h1);
						tx_st_r <= sspf_pkg::TX_DIG;
					end
					sspf_pkg::TX_STAR: tx_st_r <= sspf_pkg::TX_HX1;
					sspf_pkg::TX_HX1: tx_st_r <= sspf_pkg::TX_HX0;
					default: tx_st_r <= sspf_pkg::TX_IDLE;
				endcase
			end
		end
	end
endmodule // sspf_device_end
`default_nettype wire

// >>> sspf_pkg.sv
// Constants, types and helpers shared by both ends of the packet framer
package sspf_pkg;
	// ----------------------------------------------------------------
	// Binary framing
	// ----------------------------------------------------------------
	localparam logic [7:0] SYNC_S = 8'h73;
	localparam logic [7:0] SYNC_N = 8'h6E;
	localparam logic [7:0] SYNC_P = 8'h70;
	localparam int PT_DATA = 7;
	localparam int PT_BATCH = 6;
	localparam int PT_CNT_LSB = 2;
	localparam int PT_HIDDEN = 1;
	localparam int PT_FAIL = 0;
	localparam logic [7:0] HOST_PT_MASK = 8'hFC;
	localparam logic [6:0] STEP_DATA = 7'h05;
	localparam logic [15:0] SUM_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// ----------------------------------------------------------------
	// Quaternion sentence
	// ----------------------------------------------------------------
	localparam int DIGITS = 13;
	localparam int TIME_FRAC = 3;
	localparam int QUAT_DIGITS = 8;
	localparam int QUAT_FRAC = 5;
	localparam logic [3:0] LAST_DIGIT = 4'(DIGITS - 1);
	localparam logic [3:0] TIME_LAST_INT = 4'(DIGITS - 1 - TIME_FRAC);
	localparam logic [3:0] QUAT_LAST_INT = 4'(DIGITS - 1 - QUAT_FRAC);
	localparam logic [2:0] HDR_LAST = 3'h5;
	localparam logic [2:0] FIELDS = 3'h5;
	localparam logic [7:0] ASC_COMMA = 8'h2C;
	localparam logic [7:0] ASC_STAR = 8'h2A;
	localparam logic [7:0] ASC_DOT = 8'h2E;
	localparam logic [7:0] ASC_MINUS = 8'h2D;
	localparam logic [7:0] ASC_ZERO = 8'h30;

	typedef enum logic [8:0] {
		RX_S = 9'h001, RX_N = 9'h002, RX_P = 9'h004, RX_PT = 9'h008,
		RX_ADR = 9'h010, RX_DAT = 9'h020, RX_CK1 = 9'h040,
		RX_CK0 = 9'h080, RX_OUT = 9'h100
	} sspf_rx_t;

	typedef enum logic [9:0] {
		TX_IDLE = 10'h001, TX_BIN = 10'h002, TX_HDR = 10'h004,
		TX_SIGN = 10'h008, TX_DIG = 10'h010, TX_DOT = 10'h020,
		TX_COMMA = 10'h040, TX_STAR = 10'h080, TX_HX1 = 10'h100,
		TX_HX0 = 10'h200
	} sspf_tx_t;

	// Data section length in bytes, taken from the type byte alone
	function automatic logic [6:0] data_len(input logic [7:0] pt);
		if (!pt[PT_DATA])
			return 7'h00;
		if (!pt[PT_BATCH])
			return 7'h04;
		return {1'b0, pt[5:2], 2'b00};
	endfunction

	// Registers touched by one packet
	function automatic logic [4:0] reg_count(input logic [7:0] pt);
		return pt[PT_BATCH] ? {1'b0, pt[5:2]} : 5'h01;
	endfunction

	// A batch with a zero count is malformed
	function automatic logic pt_ok(input logic [7:0] pt);
		return !(pt[PT_BATCH] && pt[5:2] == 4'h0);
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < 4'hA) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
	endfunction

	function automatic logic [7:0] hdr_char(input logic [2:0] i);
		unique case (i)
			3'h0: return 8'h24;
			3'h1: return 8'h50;
			3'h2: return 8'h43;
			3'h3: return 8'h48;
			3'h4: return 8'h52;
			default: return 8'h51;
		endcase
	endfunction
endpackage

// >>> sspf_link_if.sv
// Byte stream link between the sensor end and the host end
`timescale 1ns/1ns
`default_nettype none
interface sspf_link_if (
	input wire logic clk
);
	logic       h2d_valid;
	logic       h2d_ready;
	logic [7:0] h2d_data;
	logic       d2h_valid;
	logic       d2h_ready;
	logic [7:0] d2h_data;

	modport device (
		input  h2d_valid, h2d_data, d2h_ready,
		output h2d_ready, d2h_valid, d2h_data
	);
	modport host (
		output h2d_valid, h2d_data, d2h_ready,
		input  h2d_ready, d2h_valid, d2h_data
	);
endinterface
`default_nettype wire

// >>> sspf_host_end.sv
// Host end: frames commands to the sensor and parses its binary replies
`timescale 1ns/1ns
`default_nettype none
module sspf_host_end (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Link
	sspf_link_if.host        link,
	// Commands out
	input  wire logic        cmd_req,
	input  wire logic [7:0]  cmd_pt,
	input  wire logic [7:0]  cmd_addr,
	input  wire logic [31:0] cmd_word,
	output logic [3:0]       cmd_word_idx,
	output logic             cmd_busy,
	output logic             cmd_refused,
	// Replies in
	input  wire logic        rsp_ready,
	output logic             rsp_word_valid,
	output logic [31:0]      rsp_word,
	output logic [3:0]       rsp_word_idx,
	output logic             rsp_valid,
	output logic [7:0]       rsp_pt,
	output logic [7:0]       rsp_addr,
	output logic             rsp_failed,
	output logic             rsp_dropped
);
	// ----------------------------------------------------------------
	// Command framer
	// ----------------------------------------------------------------
	sspf_pkg::sspf_tx_t tx_st_r;
	logic [6:0]  step_r;
	logic [7:0]  tpt_r;
	logic [7:0]  tadr_r;
	logic [15:0] tsum_r;
	logic        tval_r;
	logic [7:0]  tdat_r;
	logic        slot;
	logic [6:0]  tlen;
	logic [6:0]  k;
	logic [7:0]  tb;
	logic [7:0]  clean_pt;

	assign link.h2d_valid = tval_r;
	assign link.h2d_data = tdat_r;
	assign slot = !tval_r || link.h2d_ready;
	assign tlen = sspf_pkg::data_len(tpt_r);
	assign k = 7'(step_r - sspf_pkg::STEP_DATA);
	assign cmd_word_idx = k[5:2];
	assign cmd_busy = (tx_st_r != sspf_pkg::TX_IDLE);
	assign clean_pt = cmd_pt & sspf_pkg::HOST_PT_MASK;

	always_comb begin
		if (step_r == 7'h00)
			tb = sspf_pkg::SYNC_S;
		else if (step_r == 7'h01)
			tb = sspf_pkg::SYNC_N;
		else if (step_r == 7'h02)
			tb = sspf_pkg::SYNC_P;
		else if (step_r == 7'h03)
			tb = tpt_r;
		else if (step_r == 7'h04)
			tb = tadr_r;
		else if (k < tlen)
			tb = cmd_word[{~k[1:0], 3'b000} +: 8];
		else if (k == tlen)
			tb = tsum_r[15:8];
		else
			tb = tsum_r[7:0];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_st_r <= sspf_pkg::TX_IDLE;
			step_r <= 7'h00;
			tpt_r <= sspf_pkg::BYTE_RST;
			tadr_r <= sspf_pkg::BYTE_RST;
			tsum_r <= sspf_pkg::SUM_RST;
			tval_r <= 1'b0;
			tdat_r <= sspf_pkg::BYTE_RST;
			cmd_refused <= 1'b0;
		end else begin
			cmd_refused <= 1'b0;
			if (slot)
				tval_r <= 1'b0;
			if (tx_st_r == sspf_pkg::TX_IDLE) begin
				step_r <= 7'h00;
				tsum_r <= sspf_pkg::SUM_RST;
				if (cmd_req && !sspf_pkg::pt_ok(clean_pt))
					cmd_refused <= 1'b1;
				else if (cmd_req) begin
					tx_st_r <= sspf_pkg::TX_BIN;
					tpt_r <= clean_pt;
					tadr_r <= cmd_addr;
				end
			end else if (slot) begin
				tval_r <= 1'b1;
				tdat_r <= tb;
				step_r <= 7'(step_r + 7'h01);
				if (k < tlen || step_r < sspf_pkg::STEP_DATA)
					tsum_r <= 16'(tsum_r + {8'h00, tb});
				if (k == 7'(tlen + 7'h01))
					tx_st_r <= sspf_pkg::TX_IDLE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Reply parser
	// ----------------------------------------------------------------
	sspf_pkg::sspf_rx_t rx_st_r;
	logic [7:0]  ck_hi_r;
	logic [15:0] rsum_r;
	logic [5:0]  cnt_r;
	logic [31:0] mem [16];
	logic        take;
	logic [7:0]  b;
	logic [6:0]  rlen;
	logic        dat_st;

	assign link.d2h_ready = (rx_st_r != sspf_pkg::RX_OUT);
	assign take = link.d2h_valid && link.d2h_ready;
	assign b = link.d2h_data;
	assign rlen = sspf_pkg::data_len(rsp_pt);
	assign dat_st = rx_st_r == sspf_pkg::RX_DAT;

	always_ff @(posedge clk) begin
		if (take && dat_st)
			mem[cnt_r[5:2]] <= {mem[cnt_r[5:2]][23:0], b};
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_st_r <= sspf_pkg::RX_S;
			ck_hi_r <= sspf_pkg::BYTE_RST;
			rsum_r <= sspf_pkg::SUM_RST;
			cnt_r <= 6'h00;
			rsp_word_valid <= 1'b0;
			rsp_word <= 32'h0000_0000;
			rsp_word_idx <= 4'h0;
			rsp_valid <= 1'b0;
			rsp_pt <= sspf_pkg::BYTE_RST;
			rsp_addr <= sspf_pkg::BYTE_RST;
			rsp_failed <= 1'b0;
			rsp_dropped <= 1'b0;
		end else begin
			rsp_word_valid <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_dropped <= 1'b0;
			if (take && rx_st_r inside {sspf_pkg::RX_PT, sspf_pkg::RX_ADR,
					sspf_pkg::RX_DAT, sspf_pkg::RX_N, sspf_pkg::RX_P})
				rsum_r <= 16'(rsum_r + {8'h00, b});
			unique case (rx_st_r)
				sspf_pkg::RX_S: if (take && b == sspf_pkg::SYNC_S) begin
					rx_st_r <= sspf_pkg::RX_N;
					rsum_r <= {8'h00, sspf_pkg::SYNC_S};
				end
				sspf_pkg::RX_N, sspf_pkg::RX_P: if (take) begin
					if (rx_st_r == sspf_pkg::RX_N && b == sspf_pkg::SYNC_N)
						rx_st_r <= sspf_pkg::RX_P;
					else if (rx_st_r == sspf_pkg::RX_P && b == sspf_pkg::SYNC_P)
						rx_st_r <= sspf_pkg::RX_PT;
					else if (b == sspf_pkg::SYNC_S) begin
						rx_st_r <= sspf_pkg::RX_N;
						rsum_r <= {8'h00, sspf_pkg::SYNC_S};
					end else
						rx_st_r <= sspf_pkg::RX_S;
				end
				sspf_pkg::RX_PT: if (take) begin
					rsp_pt <= b;
					cnt_r <= 6'h00;
					rx_st_r <= sspf_pkg::RX_ADR;
				end
				sspf_pkg::RX_ADR: if (take) begin
					rsp_addr <= b;
					rx_st_r <= (rlen == 7'h00) ? sspf_pkg::RX_CK1
						: sspf_pkg::RX_DAT;
				end
				sspf_pkg::RX_DAT: if (take) begin
					cnt_r <= 6'(cnt_r + 6'h01);
					if ({1'b0, cnt_r} == 7'(rlen - 7'h01))
						rx_st_r <= sspf_pkg::RX_CK1;
				end
				sspf_pkg::RX_CK1: if (take) begin
					ck_hi_r <= b;
					rx_st_r <= sspf_pkg::RX_CK0;
				end
				sspf_pkg::RX_CK0: if (take) begin
					cnt_r <= 6'h00;
					if ({ck_hi_r, b} == rsum_r && sspf_pkg::pt_ok(rsp_pt))
						rx_st_r <= sspf_pkg::RX_OUT;
					else begin
						rsp_dropped <= 1'b1;
						rx_st_r <= sspf_pkg::RX_S;
					end
				end
				sspf_pkg::RX_OUT: if (rsp_ready) begin
					if (rsp_pt[sspf_pkg::PT_DATA] &&
							cnt_r != {1'b0, sspf_pkg::reg_count(rsp_pt)}) begin
						rsp_word_valid <= 1'b1;
						rsp_word <= mem[cnt_r[3:0]];
						rsp_word_idx <= cnt_r[3:0];
						cnt_r <= 6'(cnt_r + 6'h01);
					end else begin
						rsp_valid <= 1'b1;
						rsp_failed <= rsp_pt[sspf_pkg::PT_FAIL];
						rx_st_r <= sspf_pkg::RX_S;
					end
				end
			endcase
		end
	end
endmodule // sspf_host_end
`default_nettype wire

// >>> sspf_link_properties.sv
// Link assertions for the packet framer
`timescale 1ns/1ns
`default_nettype none
module sspf_link_properties (
	// Clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// Host to sensor
	input wire logic       h2d_valid,
	input wire logic       h2d_ready,
	input wire logic [7:0] h2d_data,
	// Sensor to host
	input wire logic       d2h_valid,
	input wire logic       d2h_ready,
	input wire logic [7:0] d2h_data
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	logic [7:0] pos_r;
	// ----
	// Bytes taken in the current packet
	// ----
	always_ff @(posedge clk) begin
		if (sys_rst || !h2d_valid)
			pos_r <= 8'h00;
		else if (h2d_ready)
			pos_r <= pos_r + 8'h01;
	end
	h_hold_a: assert property (
		h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
		else $error("h2d byte lost");
	d_hold_a: assert property (
		d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
		else $error("d2h byte lost");
	rst_idle_a: assert property (disable iff (1'b0)
		sys_rst |=> !h2d_valid && !d2h_valid && h2d_ready && d2h_ready)
		else $error("link busy in reset");
	h_start_a: assert property (
		$rose(h2d_valid) |-> h2d_data == sspf_pkg::SYNC_S)
		else $error("packet not opened by s");
	h_sync_a: assert property (
		h2d_valid && pos_r == 8'h01 |-> h2d_data == sspf_pkg::SYNC_N)
		else $error("second byte not n");
	h_sync2_a: assert property (
		h2d_valid && pos_r == 8'h02 |-> h2d_data == sspf_pkg::SYNC_P)
		else $error("third byte not p");
	h_type_a: assert property (
		h2d_valid && pos_r == 8'h03 |-> h2d_data[1:0] == 2'h0)
		else $error("host type low bits set");
	h_count_a: assert property (
		h2d_valid && pos_r == 8'h03 && h2d_data[6] |-> h2d_data[5:2] != 4'h0)
		else $error("empty batch sent");
	cover property (h2d_valid && pos_r == 8'h03 && h2d_data[7:6] == 2'h3);
	cover property (d2h_valid && !d2h_ready);
	cover property ($rose(d2h_valid) && d2h_data == 8'h24);
endmodule // sspf_link_properties
`default_nettype wire

// >>> tb.sv
// Bench for both framer ends joined by the link
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cmd_req = 1'b0;
	logic        tx_req = 1'b0;
	logic        q_req = 1'b0;
	logic        q_mode = 1'b0;
	logic        rsp_ready = 1'b1;
	logic [7:0]  pt_r = 8'h00;
	logic [7:0]  ad_r = 8'h00;
	logic        wr_en, rd_req, tx_busy, cmd_busy, cmd_refused;
	logic        wr_hidden, rd_hidden, pkt_dropped, rsp_dropped;
	logic        rsp_word_valid, rsp_valid, rsp_failed;
	logic [7:0]  wr_addr, rd_addr, rsp_pt, rsp_addr;
	logic [31:0] wr_data, rsp_word;
	logic [4:0]  rd_count;
	logic [3:0]  tx_word_idx, cmd_word_idx, rsp_word_idx;
	logic [7:0]  hq[$];
	logic [7:0]  dq[$];
	int          nw, nr, nq, nv, nh, nd, cyc, miscompares, n_tests;
	// Direction, type, address, expected words or registers
	logic [24:0] rows[6] = '{25'h0001001, 25'h04C2003, 25'h0833001,
		25'h0FC400F, 25'h1C85002, 25'h1016000};

	sspf_link_if sspf_link_if_inst (.clk(clk));
	sspf_device_end sspf_device_end_inst (
		.clk(clk), .sys_rst(sys_rst), .link(sspf_link_if_inst),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_hidden(wr_hidden),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_count(rd_count),
		.rd_hidden(rd_hidden), .pkt_dropped(pkt_dropped),
		.tx_req(tx_req), .tx_pt(pt_r),
		.tx_addr(ad_r), .tx_word({24'h5A3C00, 4'h0, tx_word_idx}),
		.tx_word_idx(tx_word_idx), .tx_busy(tx_busy), .quat_mode(q_mode),
		.q_req(q_req), .q_time_bcd(52'h0000000105015),
		.q_elem_bcd(128'h00076592000765920123456700076592),
		.q_elem_neg(4'h2));
	sspf_host_end sspf_host_end_inst (
		.clk(clk), .sys_rst(sys_rst), .link(sspf_link_if_inst),
		.cmd_req(cmd_req), .cmd_pt(pt_r), .cmd_addr(ad_r),
		.cmd_word({24'hC3A500, 4'h0, cmd_word_idx}),
		.cmd_word_idx(cmd_word_idx), .cmd_busy(cmd_busy),
		.cmd_refused(cmd_refused), .rsp_ready(rsp_ready),
		.rsp_word_valid(rsp_word_valid), .rsp_word(rsp_word),
		.rsp_word_idx(rsp_word_idx), .rsp_valid(rsp_valid),
		.rsp_pt(rsp_pt), .rsp_addr(rsp_addr), .rsp_failed(rsp_failed),
		.rsp_dropped(rsp_dropped));
	sspf_link_properties sspf_link_properties_inst (
		.clk(clk), .sys_rst(sys_rst),
		.h2d_valid(sspf_link_if_inst.h2d_valid),
		.h2d_ready(sspf_link_if_inst.h2d_ready),
		.h2d_data(sspf_link_if_inst.h2d_data),
		.d2h_valid(sspf_link_if_inst.d2h_valid),
		.d2h_ready(sspf_link_if_inst.d2h_ready),
		.d2h_data(sspf_link_if_inst.d2h_data));

	initial forever #25 clk = ~clk;
	// Host user stalls replies every other cycle
	always @(posedge clk) rsp_ready <= ~rsp_ready;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	// Outputs are looked at mid-cycle, where they have settled
	always @(negedge clk) begin
		if (wr_en) begin
			chk("wr_addr", {24'h0, ad_r + 8'(nw)}, {24'h0, wr_addr});
			chk("wr_data", {24'hC3A500, 8'(nw)}, wr_data);
			chk("wr_hidden", 0, wr_hidden);
			nw++;
		end
		if (rsp_word_valid) begin
			chk("rsp_word", {24'h5A3C00, 8'(nq)}, rsp_word);
			chk("rsp_word_idx", nq, rsp_word_idx);
			nq++;
		end
		if (rsp_dropped)
			nh++;
		if (pkt_dropped)
			nd++;
		if (rd_req)
			nr++;
		if (rsp_valid)
			nv++;
		if (sspf_link_if_inst.h2d_valid && sspf_link_if_inst.h2d_ready)
			hq.push_back(sspf_link_if_inst.h2d_data);
		if (sspf_link_if_inst.d2h_valid && sspf_link_if_inst.d2h_ready)
			dq.push_back(sspf_link_if_inst.d2h_data);
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s exp %0h got %0h", nm, e, g);
		end
	endtask
	function automatic int plen(input logic [7:0] p);
		return 7 + (p[7] ? (p[6] ? 4 * p[5:2] : 4) : 0);
	endfunction
	task automatic sum_ok(ref logic [7:0] q[$], input int n);
		logic [15:0] s;
		s = 16'h0000;
		chk("length", n, q.size());
		for (int i = 0; i + 2 < q.size(); i++)
			s += {8'h00, q[i]};
		chk("sum", {16'h0, s}, {16'h0, q[q.size() - 2], q[q.size() - 1]});
	endtask
	task automatic send(input logic d, input logic [7:0] p, a, n);
		int k;
		nw = 0;
		nr = 0;
		nq = 0;
		nv = 0;
		hq.delete();
		dq.delete();
		pt_r <= p;
		ad_r <= a;
		if (d)
			tx_req <= 1'b1;
		else
			cmd_req <= 1'b1;
		k = 0;
		do @(negedge clk); while (!(d ? tx_busy : cmd_busy) && ++k < 20);
		@(posedge clk);
		tx_req <= 1'b0;
		cmd_req <= 1'b0;
		k = 0;
		do @(negedge clk);
		while (!(d ? nv > 0 : (p[7] ? nw == n : nr > 0)) && ++k < 300);
		chk("timeout", 0, k >= 300);
		repeat (4) @(posedge clk);
		if (d)
			chk("addr", a, rsp_addr);
		else if (p[7])
			chk("addr", 8'(a + n - 8'h01), wr_addr);
		else
			chk("addr", a, rd_addr);
		if (d) begin
			sum_ok(dq, plen(p));
			chk("rsp_words", n, nq);
			chk("rsp_pt", p, rsp_pt);
			chk("rsp_failed", p[0], rsp_failed);
		end else begin
			sum_ok(hq, plen(p & 8'hFC));
			chk("writes", p[7] ? n : 0, nw);
			chk("reads", p[7] ? 0 : 1, nr);
			if (!p[7]) begin
				chk("rd_count", n, rd_count);
				chk("rd_hidden", 0, rd_hidden);
			end
		end
	endtask
	task automatic finish_test();
		$display("tests %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		int k;
		logic [7:0] x;
		string s, g;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (rows[i])
			send(rows[i][24], rows[i][23:16], rows[i][15:8], rows[i][7:0]);
		// Batch with no registers is refused before any byte goes out
		pt_r <= 8'h40;
		cmd_req <= 1'b1;
		q_req <= 1'b1;
		hq.delete();
		dq.delete();
		k = 0;
		do @(negedge clk); while (cmd_refused !== 1'b1 && ++k < 20);
		chk("refused", 1, cmd_refused);
		@(posedge clk);
		cmd_req <= 1'b0;
		q_req <= 1'b0;
		repeat (20) @(posedge clk);
		chk("no_bytes", 0, hq.size() + dq.size());
		// A reply carrying an empty batch is dropped by the host
		nh = 0;
		nv = 0;
		tx_req <= 1'b1;
		@(posedge clk);
		tx_req <= 1'b0;
		repeat (30) @(posedge clk);
		chk("dropped", 1, nh);
		chk("drop_valid", 0, nv);
		s = $sformatf("%s,105.015,0.76592,-12.34567,0.76592,0.76592,",
			40'h5043485251);
		x = 8'h00;
		foreach (s[i])
			x ^= s[i];
		s = {"$", s, "*", $sformatf("%02X", x)};
		dq.delete();
		q_mode <= 1'b1;
		q_req <= 1'b1;
		@(posedge clk);
		q_req <= 1'b0;
		k = 0;
		do @(negedge clk); while (dq.size() < s.len() && ++k < 400);
		g = "";
		foreach (dq[i])
			g = {g, $sformatf("%c", dq[i])};
		chk("sentence", 1, s == g);
		// Reset in mid-packet leaves both ends idle, then hunting again
		@(posedge clk);
		pt_r <= 8'hFC;
		cmd_req <= 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b1;
		cmd_req <= 1'b0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk("rst_idle", 0, {cmd_busy, tx_busy, sspf_link_if_inst.h2d_valid,
			sspf_link_if_inst.d2h_valid});
		@(posedge clk);
		send(1'b0, 8'h00, 8'h10, 8'h01);
		chk("dev_drops", 0, nd);
		finish_test();
	end
endmodule // tb
`default_nettype wire
